// File: dv/ris_irq_status_properties.sv
// port assertions for the radio interrupt and status block
`default_nettype none

module ris_irq_status_properties
  import ris_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic spi_sclk_i,
  input wire logic spi_sel_n_i,
  input wire logic spi_sdo_o,
  input wire logic spi_sdo_oe_o,
  input wire logic interrupt_request_low_o
);
  // ==========================================================
  // assertions on the serial pins and the interrupt pin
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  out_reset_a: assert property ($fell(rst_i) |-> interrupt_request_low_o
    && !spi_sdo_oe_o && !spi_sdo_o) else $error("outputs busy after reset");
  oe_idle_a: assert property (spi_sel_n_i [*6] |-> !spi_sdo_oe_o)
    else $error("sdo enabled while deselected");
  sdo_idle_a: assert property (spi_sel_n_i [*6] |-> !spi_sdo_o)
    else $error("sdo high while deselected");
  oe_start_a: assert property ($rose(spi_sdo_oe_o) |->
    !spi_sel_n_i && spi_sclk_i) else $error("sdo enabled off the frame");
  oe_hold_a: assert property (spi_sdo_oe_o && !spi_sel_n_i |=> spi_sdo_oe_o)
    else $error("sdo enable dropped while selected");
  sdo_shift_a: assert property (spi_sdo_oe_o && $past(spi_sdo_oe_o) &&
    $changed(spi_sdo_o) |-> !spi_sclk_i)
    else $error("sdo moved in high phase");
  irq_hold_a: assert property (!interrupt_request_low_o &&
    spi_sel_n_i |=> !interrupt_request_low_o)
    else $error("irq released without a read");
  irq_release_a: assert property ($rose(interrupt_request_low_o) |->
    !spi_sel_n_i && spi_sdo_oe_o) else $error("irq released outside a read");

  // main scenarios reached
  irq_fall_c: cover property ($fell(interrupt_request_low_o));
  irq_rise_c: cover property ($rose(interrupt_request_low_o));
  read_c: cover property ($rose(spi_sdo_oe_o));
endmodule // ris_irq_status_properties

`default_nettype wire

// File: dv/ris_irq_status_tb.sv
// self-checking bench for the radio interrupt and status block
`default_nettype none

module ris_irq_status_tb
  import ris_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // stimulus, observed pins and counters
  logic        mclk_i = 1'b0;
  logic        rst_i  = 1'b1;
  logic [18:0] ev     = '0; // events; 16..18 are levels
  logic        fmode  = 1'b1;
  logic        path   = 1'b0;
  logic        idle   = 1'b0;
  logic [6:0]  txc    = 7'h05;
  logic [6:0]  rxc    = 7'h00;
  logic        sclk, sdi, sel_n, sdo, sdo_oe, irq;
  int          error_cnt = 0;
  int          n_tests   = 0;

  // 10 MHz clock
  always #50 mclk_i = ~mclk_i;

  ris_irq_status ris_irq_status_inst (.mclk_i(mclk_i), .rst_i(rst_i),
    .spi_sclk_i(sclk), .spi_sdi_i(sdi), .spi_sel_n_i(sel_n),
    .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe), .tx_fifo_error_i(ev[0]),
    .rx_fifo_error_i(ev[1]), .tx_fifo_reset_i(ev[2]),
    .rx_fifo_reset_i(ev[3]), .tx_fifo_count_i(txc), .tx_afull_thr_i(7'h0a),
    .tx_aempty_thr_i(7'h02), .rx_fifo_count_i(rxc), .rx_afull_thr_i(7'h0a),
    .ext_event_i(1'b0), .pkt_sent_i(ev[4]), .fifo_mode_i(fmode),
    .tx_start_i(ev[5]), .pkt_valid_i(ev[6]), .sync_accepted_i(ev[7]),
    .crc_fail_i(ev[8]), .rx_data_start_i(ev[9]), .sync_detect_i(ev[10]),
    .rx_packet_done_i(ev[11]), .preamble_detect_i(ev[12]),
    .sync_timeout_i(ev[13]), .preamble_invalid_i(ev[16]),
    .rssi_above_i(ev[18]), .wut_expired_i(ev[14]), .low_battery_i(ev[15]),
    .path_enable_i(path), .device_idle_i(idle), .por_event_i(ev[17]),
    .interrupt_request_low_o(irq));
  ris_spi_host ris_spi_host_inst (.mclk_i(mclk_i), .sdo_i(sdo),
    .sclk_o(sclk), .sdi_o(sdi), .sel_n_o(sel_n));

  // ==========================================================
  // compare, bus and event tasks
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // irq level checked first, then the register read compared
  task automatic rd(input logic [6:0] a, input logic [7:0] e, input logic i);
    logic [7:0] q;
    repeat (4) @(negedge mclk_i);
    chk8({7'h00, irq}, {7'h00, i});
    ris_spi_host_inst.xfer({1'b0, a, 8'h00}, q);
    chk8(q, e);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    ris_spi_host_inst.xfer({1'b1, a, d}, q);
  endtask
  task automatic pulse(input int k);
    ev[k] = 1'b1;
    @(negedge mclk_i);
    ev[k] = 1'b0;
    @(negedge mclk_i);
  endtask
  task automatic ep(input int k, input logic [6:0] a, input logic [7:0] e);
    pulse(k);
    rd(a, e, 1'b1);
  endtask
  task automatic conclude;
    $display("tests=%0d errors=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs;
    rd(ADDR_EN1, EN1_RESET, 1'b1);
    rd(ADDR_EN2, EN2_RESET, 1'b1);
    wr(ADDR_STAT1, 8'hff);
    rd(ADDR_STAT1, STAT_RESET, 1'b1);
    rd(7'h07, 8'h00, 1'b1);
    wr(ADDR_EN2, 8'ha5);
    rd(ADDR_EN2, 8'ha5, 1'b1);
    wr(ADDR_EN2, EN2_RESET);
  endtask
  // first status bits as plain status
  task automatic t_fifo;
    ep(1, ADDR_STAT1, 8'h80);
    ep(2, ADDR_STAT1, 8'h80);
    ep(3, ADDR_STAT1, 8'h00);
    ep(0, ADDR_STAT1, 8'h80);
    ep(3, ADDR_STAT1, 8'h80);
    ep(2, ADDR_STAT1, 8'h00);
    txc = 7'h0b;
    rd(ADDR_STAT1, 8'h40, 1'b1);
    txc = 7'h0a;
    rd(ADDR_STAT1, 8'h00, 1'b1);
    txc = 7'h02;
    rd(ADDR_STAT1, 8'h20, 1'b1);
    txc = 7'h03;
    rd(ADDR_STAT1, 8'h00, 1'b1);
    rxc = 7'h0b;
    rd(ADDR_STAT1, 8'h10, 1'b1);
    rxc = 7'h0a;
    rd(ADDR_STAT1, 8'h10, 1'b1);
    rxc = 7'h09;
    rd(ADDR_STAT1, 8'h00, 1'b1);
    ep(4, ADDR_STAT1, 8'h04);
    ep(5, ADDR_STAT1, 8'h00);
    pulse(4);
    fmode = 1'b0;
    rd(ADDR_STAT1, 8'h00, 1'b1);
    fmode = 1'b1;
    ep(6, ADDR_STAT1, 8'h02);
    ep(7, ADDR_STAT1, 8'h00);
    ep(8, ADDR_STAT1, 8'h01);
    ep(9, ADDR_STAT1, 8'h00);
  endtask
  // second status bits as plain status
  task automatic t_stat2;
    ep(12, ADDR_STAT2, 8'h40);
    ep(10, ADDR_STAT2, 8'h80);
    ep(11, ADDR_STAT2, 8'h00);
    pulse(12);
    ep(13, ADDR_STAT2, 8'h00);
    ev[18:16] = 3'h7;
    rd(ADDR_STAT2, 8'h31, 1'b1);
    rd(ADDR_STAT2, 8'h31, 1'b1);
    ev[18:16] = 3'h0;
  endtask
  // interrupts from both registers, clear on read
  task automatic t_irq;
    ev[18] = 1'b1;
    wr(ADDR_EN2, 8'h08);
    pulse(14);
    rd(ADDR_STAT2, 8'h18, 1'b0);
    rd(ADDR_STAT2, 8'h10, 1'b1);
    ev[18] = 1'b0;
    wr(ADDR_EN2, 8'h00);
    pulse(15);
    rd(ADDR_STAT2, 8'h04, 1'b1);
    wr(ADDR_EN2, 8'h04);
    rd(ADDR_STAT2, 8'h04, 1'b0);
    rd(ADDR_STAT2, 8'h00, 1'b1);
    wr(ADDR_EN1, 8'h01);
    rd(ADDR_EN1, 8'h01, 1'b1);
    wr(ADDR_EN2, 8'h08);
    pulse(8);
    pulse(14);
    rd(ADDR_STAT2, 8'h08, 1'b0);
    rd(ADDR_STAT1, 8'h01, 1'b0);
    rd(ADDR_STAT1, 8'h00, 1'b1);
    pulse(9);
    wr(ADDR_EN1, 8'h00);
    wr(ADDR_EN2, 8'h00);
  endtask
  // chip ready after the 1000-cycle settling time, dropped in idle
  task automatic t_ready;
    path = 1'b1;
    rd(ADDR_STAT2, 8'h00, 1'b1);
    repeat (1000) @(negedge mclk_i);
    rd(ADDR_STAT2, 8'h02, 1'b1);
    idle = 1'b1;
    rd(ADDR_STAT2, 8'h00, 1'b1);
  endtask

  // main sequence after a 4-cycle reset
  initial
  begin
    repeat (4) @(negedge mclk_i);
    rst_i = 1'b0;
    t_regs();
    t_fifo();
    t_stat2();
    t_irq();
    t_ready();
    conclude();
  end
  // watchdog: the run needs about 1 ms
  initial
  begin
    #4000000;
    error_cnt++;
    conclude();
  end
endmodule // ris_irq_status_tb

bind ris_irq_status ris_irq_status_properties ris_irq_status_properties_inst (
  .mclk_i(mclk_i), .rst_i(rst_i), .spi_sclk_i(spi_sclk_i),
  .spi_sel_n_i(spi_sel_n_i), .spi_sdo_o(spi_sdo_o),
  .spi_sdo_oe_o(spi_sdo_oe_o),
  .interrupt_request_low_o(interrupt_request_low_o));

`default_nettype wire

// File: dv/ris_spi_host.sv
// behavioural host that reads and writes registers over the serial port
`default_nettype none

module ris_spi_host
(
  input  wire logic mclk_i,
  input  wire logic sdo_i,
  output var  logic sclk_o,
  output var  logic sdi_o,
  output var  logic sel_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // pins idle at time zero, clock low outside frames
  initial
  begin
    sclk_o = 1'b0;
    sdi_o = 1'b0;
    sel_n_o = 1'b1;
  end

  // one framed 16-bit transfer, msb first, 5-cycle half periods
  task automatic xfer(input logic [15:0] w, output logic [7:0] q);
    int i;
    q = 8'h00;
    sel_n_o = 1'b0;
    for (i = 15; i >= 0; i--)
    begin
      sdi_o = w[i];
      repeat (5) @(negedge mclk_i);
      sclk_o = 1'b1;
      if (i < 8)
        q[i] = sdo_i; // sampled on the rising clock
      repeat (5) @(negedge mclk_i);
      sclk_o = 1'b0;
    end
    repeat (8) @(negedge mclk_i);
    sel_n_o = 1'b1;
    sdi_o = ~sdi_o; // released line shows no stale bit
    repeat (5) @(negedge mclk_i);
  endtask
endmodule // ris_spi_host

`default_nettype wire

// File: include/ris_pkg.sv
// constants and types shared by the radio interrupt and status block
`default_nettype none

package ris_pkg;

  // ==========================================================================
  // register addresses on the serial port
  localparam logic [6:0] ADDR_STAT1 = 7'h03; // first status register
  localparam logic [6:0] ADDR_STAT2 = 7'h04; // event_status_second
  localparam logic [6:0] ADDR_EN1   = 7'h05; // enables of first status
  localparam logic [6:0] ADDR_EN2   = 7'h06; // enables of second status

  // ==========================================================================
  // serial framing
  localparam int         WRITE_BIT = 7;       // address byte msb: 1 = write
  localparam logic [2:0] BIT_LAST  = 3'h7;    // last bit of a byte

  // ==========================================================================
  // first status register bit positions
  localparam int B1_FIFO_ERR  = 7;
  localparam int B1_TX_AFULL  = 6;
  localparam int B1_TX_AEMPTY = 5;
  localparam int B1_RX_AFULL  = 4;
  localparam int B1_EXT       = 3;
  localparam int B1_PKT_SENT  = 2;
  localparam int B1_PKT_VALID = 1;
  localparam int B1_CRC_FAIL  = 0;

  // ==========================================================================
  // second status register bit positions
  localparam int B2_SYNC      = 7;
  localparam int B2_PRE_VALID = 6;
  localparam int B2_PRE_INVAL = 5;
  localparam int B2_RSSI      = 4;
  localparam int B2_WUT       = 3;
  localparam int B2_LOW_BATT  = 2;
  localparam int B2_CHIP_RDY  = 1;
  localparam int B2_POWER_ON  = 0;

  // ==========================================================================
  // reset values and fixed masks
  localparam logic [7:0] EN1_RESET     = 8'h00;
  localparam logic [7:0] EN2_RESET     = 8'h00;
  localparam logic [7:0] STAT_RESET    = 8'h00;
  localparam logic [7:0] LATCH_ALWAYS1 = 8'h00; // no bit latches unenabled
  localparam logic [7:0] LATCH_ALWAYS2 = 8'h04; // low battery always latches

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 100; // mclk_i at 10 MHz

  // ==========================================================================
  // serial port phases
  typedef enum logic [1:0] {
    RIS_ADDR,
    RIS_DATA,
    RIS_DONE
  } ris_spi_t;

endpackage : ris_pkg

`default_nettype wire

// File: logic/ris_irq_status.sv
// interrupt and status logic of the packet radio, with its serial port
`default_nettype none

module ris_irq_status
  import ris_pkg::*;
#(
  parameter int FIFO_W    = 7,      // fifo byte count width
  parameter int SETTLE_NS = 100000  // crystal settling time in ns
)(
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  // serial register port pins
  input  wire logic              spi_sclk_i,
  input  wire logic              spi_sdi_i,
  input  wire logic              spi_sel_n_i,
  output logic                   spi_sdo_o,
  output logic                   spi_sdo_oe_o,
  // fifo events and levels
  input  wire logic              tx_fifo_error_i,
  input  wire logic              rx_fifo_error_i,
  input  wire logic              tx_fifo_reset_i,
  input  wire logic              rx_fifo_reset_i,
  input  wire logic [FIFO_W-1:0] tx_fifo_count_i,
  input  wire logic [FIFO_W-1:0] tx_afull_thr_i,
  input  wire logic [FIFO_W-1:0] tx_aempty_thr_i,
  input  wire logic [FIFO_W-1:0] rx_fifo_count_i,
  input  wire logic [FIFO_W-1:0] rx_afull_thr_i,
  input  wire logic              ext_event_i,
  // packet handler events
  input  wire logic              pkt_sent_i,
  input  wire logic              fifo_mode_i,
  input  wire logic              tx_start_i,
  input  wire logic              pkt_valid_i,
  input  wire logic              sync_accepted_i,
  input  wire logic              crc_fail_i,
  input  wire logic              rx_data_start_i,
  // receiver, timer, supply and power events
  input  wire logic              sync_detect_i,
  input  wire logic              rx_packet_done_i,
  input  wire logic              preamble_detect_i,
  input  wire logic              sync_timeout_i,
  input  wire logic              preamble_invalid_i,
  input  wire logic              rssi_above_i,
  input  wire logic              wut_expired_i,
  input  wire logic              low_battery_i,
  input  wire logic              path_enable_i,
  input  wire logic              device_idle_i,
  input  wire logic              por_event_i,
  // interrupt to the host
  output logic                   interrupt_request_low_o
);

  // ==========================================================================
  // constants
  // the settling counter is 16 bits wide: keep SETTLE_NS below about
  // 6.5 ms at 10 MHz or the count would be cut short
  localparam int         SETTLE_INT = (SETTLE_NS + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
  localparam logic [15:0] SETTLE_CYC = 16'(SETTLE_INT); // rounded up

  // ==========================================================================
  // state
  typedef struct packed {
    logic        sclk_m;
    logic        sclk_s;
    logic        sclk_d;
    logic        sdi_m;
    logic        sdi_s;
    logic        sel_m;
    logic        sel_s;
    ris_spi_t    spi;
    logic [2:0]  bitcnt;
    logic [7:0]  shin;
    logic [7:0]  shout;
    logic        wr;
    logic [6:0]  addr;
    logic        tx_err;
    logic        rx_err;
    logic [7:0]  st1;
    logic [7:0]  st2;
    logic [7:0]  lat1;
    logic [7:0]  lat2;
    logic [7:0]  en1;
    logic [7:0]  en2;
    logic [15:0] settle;
    logic        irq_n;
    logic        sdo;
    logic        sdo_oe;
  } ris_state_t;

  ris_state_t s_reg;
  ris_state_t s_next;

  // ==========================================================================
  // register view: enabled bits show the latch, others the live status
  // low battery, kept by the keep mask, shows its latch even unenabled
  function automatic logic [7:0] ris_view(input logic [7:0] lat,
                                          input logic [7:0] st,
                                          input logic [7:0] en,
                                          input logic [7:0] keep);
    ris_view = (lat & (en | keep)) | (st & ~en);
  endfunction

  // next latch: new enabled edges set, read clears enabled bits, set wins
  function automatic logic [7:0] ris_latch(input logic [7:0] lat,
                                           input logic [7:0] rise,
                                           input logic [7:0] en,
                                           input logic [7:0] keep,
                                           input logic       rd);
    ris_latch = (lat & ~(rd ? en : 8'h00)) | (rise & (en | keep));
  endfunction

  // ==========================================================================
  // next state
  always_comb
  begin
    logic       rise_c;
    logic       fall_c;
    logic [7:0] shin_c;
    logic [7:0] rise1;
    logic [7:0] rise2;
    logic       rd1;
    logic       rd2;
    rise_c = 1'b0;
    fall_c = 1'b0;
    shin_c = 8'h00;
    rise1  = 8'h00;
    rise2  = 8'h00;
    rd1    = 1'b0;
    rd2    = 1'b0;
    s_next = s_reg;

    // pin synchronisers; only the second stage feeds logic, and a third
    // stage on the serial clock gives the edge detector its previous value
    s_next.sclk_m = spi_sclk_i;
    s_next.sclk_s = s_reg.sclk_m;
    s_next.sclk_d = s_reg.sclk_s;
    s_next.sdi_m  = spi_sdi_i;
    s_next.sdi_s  = s_reg.sdi_m;
    s_next.sel_m  = spi_sel_n_i;
    s_next.sel_s  = s_reg.sel_m;
    rise_c = s_reg.sclk_s & ~s_reg.sclk_d;
    fall_c = ~s_reg.sclk_s & s_reg.sclk_d;
    shin_c = {s_reg.shin[6:0], s_reg.sdi_s};

    // serial port: address byte, then one data byte
    // a read loads its data when the address byte completes, so the
    // clear-on-read of a status register takes effect even if the host
    // never clocks the data byte out; deselect aborts any frame
    if (s_reg.sel_s)
    begin
      s_next.spi    = RIS_ADDR;
      s_next.bitcnt = 3'h0;
      s_next.sdo    = 1'b0;
      s_next.sdo_oe = 1'b0;
    end
    else
    begin
      case (s_reg.spi)
        RIS_ADDR:
        begin
          if (rise_c)
          begin
            s_next.shin   = shin_c;
            s_next.bitcnt = s_reg.bitcnt + 3'h1;
            if (s_reg.bitcnt == BIT_LAST)
            begin
              s_next.wr   = shin_c[WRITE_BIT];
              s_next.addr = shin_c[6:0];
              s_next.spi  = RIS_DATA;
              if (!shin_c[WRITE_BIT])
              begin
                if (shin_c[6:0] == ADDR_STAT1)
                begin
                  s_next.shout = ris_view(s_reg.lat1, s_reg.st1,
                                          s_reg.en1, LATCH_ALWAYS1);
                  rd1 = 1'b1;
                end
                else if (shin_c[6:0] == ADDR_STAT2)
                begin
                  s_next.shout = ris_view(s_reg.lat2, s_reg.st2,
                                          s_reg.en2, LATCH_ALWAYS2);
                  rd2 = 1'b1;
                end
                else if (shin_c[6:0] == ADDR_EN1)
                  s_next.shout = s_reg.en1;
                else if (shin_c[6:0] == ADDR_EN2)
                  s_next.shout = s_reg.en2;
                else
                  s_next.shout = 8'h00; // unmapped reads as zero
                s_next.sdo    = s_next.shout[7];
                s_next.sdo_oe = 1'b1;
              end
            end
          end
        end
        RIS_DATA:
        begin
          if (rise_c)
          begin
            s_next.shin   = shin_c;
            s_next.bitcnt = s_reg.bitcnt + 3'h1;
            if (s_reg.bitcnt == BIT_LAST)
            begin
              s_next.spi = RIS_DONE;
              if (s_reg.wr && s_reg.addr == ADDR_EN1)
                s_next.en1 = shin_c;
              else if (s_reg.wr && s_reg.addr == ADDR_EN2)
                s_next.en2 = shin_c;
            end
          end
          // the fall right after the address byte leaves bit 7 on the pin;
          // later falls shift the next bit out ahead of the host's rise
          else if (fall_c && !s_reg.wr && s_reg.bitcnt != 3'h0)
          begin
            s_next.shout = {s_reg.shout[6:0], 1'b0};
            s_next.sdo   = s_reg.shout[6];
          end
        end
        default:
        begin
          s_next.spi = RIS_DONE; // further bytes ignored until deselect
        end
      endcase
    end

    // first status register, live conditions
    // each flag below lets its set condition win over a clear that
    // arrives in the same cycle, so no event is ever lost
    s_next.tx_err = tx_fifo_error_i | (s_reg.tx_err & ~tx_fifo_reset_i);
    s_next.rx_err = rx_fifo_error_i | (s_reg.rx_err & ~rx_fifo_reset_i);
    s_next.st1[B1_FIFO_ERR] = s_next.tx_err | s_next.rx_err;
    s_next.st1[B1_TX_AFULL] = tx_fifo_count_i > tx_afull_thr_i;
    s_next.st1[B1_TX_AEMPTY] =
      tx_fifo_count_i <= tx_aempty_thr_i;
    // rx almost full holds its value while the count equals the threshold
    if (rx_fifo_count_i > rx_afull_thr_i)
      s_next.st1[B1_RX_AFULL] = 1'b1;
    else if (rx_fifo_count_i < rx_afull_thr_i)
      s_next.st1[B1_RX_AFULL] = 1'b0;
    s_next.st1[B1_EXT] = ext_event_i;
    s_next.st1[B1_PKT_SENT] = pkt_sent_i | (s_reg.st1[B1_PKT_SENT]
      & fifo_mode_i & ~tx_start_i);
    s_next.st1[B1_PKT_VALID] = pkt_valid_i
      | (s_reg.st1[B1_PKT_VALID] & ~sync_accepted_i);
    s_next.st1[B1_CRC_FAIL] = crc_fail_i
      | (s_reg.st1[B1_CRC_FAIL] & ~rx_data_start_i);

    // second status register, live conditions
    s_next.st2[B2_SYNC] = sync_detect_i
      | (s_reg.st2[B2_SYNC] & ~rx_packet_done_i);
    s_next.st2[B2_PRE_VALID] = preamble_detect_i
      | (s_reg.st2[B2_PRE_VALID] & ~sync_detect_i
         & ~sync_timeout_i);
    s_next.st2[B2_PRE_INVAL] = preamble_invalid_i;
    s_next.st2[B2_RSSI]      = rssi_above_i;
    s_next.st2[B2_WUT]       = wut_expired_i;
    s_next.st2[B2_LOW_BATT]  = low_battery_i;
    s_next.st2[B2_POWER_ON]  = por_event_i;

    // chip ready after crystal settling, dropped in idle
    // the counter stops at the settling count, so a path enable that
    // lasts for hours never wraps it; idle restarts the wait
    if (device_idle_i)
    begin
      s_next.settle           = 16'h0000;
      s_next.st2[B2_CHIP_RDY] = 1'b0;
    end
    else if (path_enable_i)
    begin
      if (s_reg.settle >= SETTLE_CYC)
        s_next.st2[B2_CHIP_RDY] = 1'b1;
      else
        s_next.settle = s_reg.settle + 16'h0001;
    end

    // latched events and clear-on-read
    // rising edges are taken from the next live value against the
    // current one, so a one-cycle event pulse is never missed;
    // low battery latches even while its enable is clear
    rise1 = s_next.st1 & ~s_reg.st1;
    rise2 = s_next.st2 & ~s_reg.st2;
    s_next.lat1 = ris_latch(s_reg.lat1, rise1, s_reg.en1,
                            LATCH_ALWAYS1, rd1);
    s_next.lat2 = ris_latch(s_reg.lat2, rise2, s_reg.en2,
                            LATCH_ALWAYS2, rd2);

    // interrupt low while any enabled latch stands in either register
    // built from the next latches and enables, so an enable write or a
    // clearing read moves the pin in the same cycle as the register
    s_next.irq_n = ~(|(s_next.lat1 & s_next.en1)
                   | |(s_next.lat2 & s_next.en2));
  end

  // ==========================================================================
  // state register
  // synchronisers reset to the idle pin levels (clock low, select high)
  // so no false serial edge follows reset
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      s_reg        <= '0;
      s_reg.sclk_m <= 1'b0;
      s_reg.sel_m  <= 1'b1;
      s_reg.sel_s  <= 1'b1;
      s_reg.spi    <= RIS_ADDR;
      s_reg.st1    <= STAT_RESET;
      s_reg.st2    <= STAT_RESET;
      s_reg.en1    <= EN1_RESET;
      s_reg.en2    <= EN2_RESET;
      s_reg.irq_n  <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  // ==========================================================================
  // outputs straight from flip-flops
  assign spi_sdo_o               = s_reg.sdo;
  assign spi_sdo_oe_o            = s_reg.sdo_oe;
  assign interrupt_request_low_o = s_reg.irq_n;

endmodule : ris_irq_status

`default_nettype wire
